// [rtl/tiu_pkg.sv]
// Package: register map, field layout and reset values of the timer and interrupt unit
package tiu_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] TIU_OFS_RELOAD1   = 8'h00;
    localparam logic [7:0] TIU_OFS_RELOAD2   = 8'h04;
    localparam logic [7:0] TIU_OFS_COUNT1    = 8'h08;
    localparam logic [7:0] TIU_OFS_COUNT2    = 8'h0C;
    localparam logic [7:0] TIU_OFS_MASK      = 8'h10;
    localparam logic [7:0] TIU_OFS_REQUEST   = 8'h14;
    // Interrupt source bit positions
    localparam int TIU_SRC_EXT_EDGE   = 0;
    localparam int TIU_SRC_TIMER1     = 1;
    localparam int TIU_SRC_TIMER2     = 2;
    localparam int TIU_SRC_RESERVED   = 3;
    localparam int TIU_SRC_PWM_PERIOD = 4;
    localparam int TIU_NUM_SRC        = 5;
    // Reset values and the top count of a timer
    localparam logic [7:0] TIU_RELOAD_RST  = 8'h00;
    localparam logic [7:0] TIU_COUNT_RST   = 8'h00;
    localparam logic [4:0] TIU_MASK_RST    = 5'h00;
    localparam logic [4:0] TIU_REQUEST_RST = 5'h00;
    localparam logic [7:0] TIU_COUNT_MAX   = 8'hFF;
endpackage

// [rtl/tiu_timer.sv]
// One reloadable 8-bit up-counting timer fed by a synchronised tick input
`timescale 1ns/1ps
`default_nettype none
module tiu_timer (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       tickLevel,
    input  wire logic [7:0] reloadValue,
    output logic      [7:0] count,
    output logic            overflow
);
    logic tickPrev_r;
    logic tickRise;

    // Count on rising edges of the already synchronised oscillator level
    always_ff @(posedge clk) begin
        if (reset) begin
            tickPrev_r <= 1'b0;
        end else begin
            tickPrev_r <= tickLevel;
        end
    end
    assign tickRise = tickLevel & ~tickPrev_r;

    // Up counter, wraps to the reload value on passing the top
    always_ff @(posedge clk) begin
        if (reset) begin
            count    <= tiu_pkg::TIU_COUNT_RST;
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (tickRise) begin
                if (count == tiu_pkg::TIU_COUNT_MAX) begin
                    count    <= reloadValue;
                    overflow <= 1'b1;
                end else begin
                    count <= count + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/timer_interrupt_unit.sv]
// Two reloadable timers and a five-source interrupt unit behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module timer_interrupt_unit (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        firstPortLowestPin,
    input  wire logic        fastOscInput,
    input  wire logic        slowOscInput,
    input  wire logic        pwmPeriodDone,
    input  wire logic        reservedEvent,
    output logic             irq
);
    logic [7:0] reload1_r;
    logic [7:0] reload2_r;
    logic [4:0] interruptMaskReg_r;
    logic [4:0] request_r;
    logic [4:0] request_nxt;
    logic [7:0] count1;
    logic [7:0] count2;
    logic       ovf1;
    logic       ovf2;
    logic [2:0] pinSync_r;
    logic [1:0] fastSync_r;
    logic [1:0] slowSync_r;
    logic       accessCycle;
    logic       wrEn;
    logic       mapped;
    logic [4:0] events;
    logic       pinRise;
    logic       wrReload1;
    logic       wrReload2;
    logic       wrMask;
    logic       wrRequest;
    logic       rdSetup;
    logic [31:0] readMux;
    logic       irqPending;
    logic       readyNxt;
    logic       errNxt;

    // Register map, one aligned 32-bit word per register, data in the low bits:
    //   0x00  reload value of timer one, read and write
    //   0x04  reload value of timer two, read and write
    //   0x08  live count of timer one, read only
    //   0x0C  live count of timer two, read only
    //   0x10  interrupt mask, a set bit enables that source
    //   0x14  interrupt requests, sticky, write one to clear
    // Any other address answers with pslverr and reads as zero.
    // Upper data bits read as zero and are ignored on writes.
    //
    // Request and mask bit positions, shared by both registers:
    //   bit 0  rising edge on the lowest pin of the first port
    //   bit 1  overflow of timer one
    //   bit 2  overflow of timer two
    //   bit 3  reserved source, pulsed by neighbouring logic
    //   bit 4  end of a PWM sample period
    //
    // Latency seen from the bus:
    //   pin edge to request bit     three clock edges
    //   oscillator edge to count    three clock edges
    //   overflow to request bit     one clock edge
    //   request bit to irq          one clock edge
    //   setup cycle to pready       one clock edge, never a wait state
    //
    // Request register behaviour:
    //   Each source event sets its bit, and the bit stays set until
    //   software writes a one to it. Writing zero leaves a bit alone,
    //   so a handler may clear only the sources it has served.
    //   When an event and a clear of the same bit meet in one cycle the
    //   event wins; clearing a request can never lose a fresh event.
    //   Requests are recorded whether or not the source is masked, so
    //   software can poll masked sources.
    //
    // Interrupt output:
    //   irq is a registered level, high while any request bit is set
    //   together with its mask bit. It falls one edge after the last
    //   such request is cleared or masked.
    //
    // Timer behaviour:
    //   Each timer counts one tick per rising edge of its oscillator.
    //   On the tick after 0xFF the counter takes the reload value and
    //   pulses its overflow for one cycle, with no software help.
    //   A reload value written mid-period only shows at the next wrap.
    //
    // Limitations a user must know:
    //   Both oscillators are sampled as data, so each must stay below
    //   half of clk; a faster source loses ticks without any warning.
    //   Counters start from zero after reset, not from the reload value,
    //   so the first period of each timer is a full 256 ticks.
    //   Writes to the count registers are accepted and ignored.
    //   The clock may stop at any time and every register simply holds,
    //   but ticks and pin edges are only seen on clk edges and are lost meanwhile.
    //   The pin edge detector needs the pin to stay high for at least
    //   one clk period, or the rising edge may be missed.
    //
    // Trade-offs:
    //   Read data is captured in the setup cycle so that prdata comes
    //   from a flop; the price is that a count read is one cycle old.
    //   Zero wait states keep the slave simple; the bus never stalls.

    // Pin synchroniser; zero at reset matches the idle pin, so no false edge
    always_ff @(posedge clk) begin
        if (reset) begin
            pinSync_r <= 3'h0;
        end else begin
            pinSync_r <= {pinSync_r[1:0], firstPortLowestPin};
        end
    end

    // Fast oscillator synchroniser, two flops before the timer reads it
    always_ff @(posedge clk) begin
        if (reset) begin
            fastSync_r <= 2'h0;
        end else begin
            fastSync_r <= {fastSync_r[0], fastOscInput};
        end
    end

    // Slow oscillator synchroniser, two flops before the timer reads it
    always_ff @(posedge clk) begin
        if (reset) begin
            slowSync_r <= 2'h0;
        end else begin
            slowSync_r <= {slowSync_r[0], slowOscInput};
        end
    end

    // Each timer gets its own count source
    tiu_timer timer1 (
        .clk         (clk),
        .reset       (reset),
        .tickLevel   (fastSync_r[1]),
        .reloadValue (reload1_r),
        .count       (count1),
        .overflow    (ovf1)
    );
    tiu_timer timer2 (
        .clk         (clk),
        .reset       (reset),
        .tickLevel   (slowSync_r[1]),
        .reloadValue (reload2_r),
        .count       (count2),
        .overflow    (ovf2)
    );

    // Bus decode; APB access completes in the first access cycle
    assign accessCycle = psel & penable;
    assign wrEn        = accessCycle & pwrite;
    // Per-register write strobes, each valid only in the access cycle
    assign wrReload1   = wrEn & (paddr == tiu_pkg::TIU_OFS_RELOAD1);
    assign wrReload2   = wrEn & (paddr == tiu_pkg::TIU_OFS_RELOAD2);
    assign wrMask      = wrEn & (paddr == tiu_pkg::TIU_OFS_MASK);
    assign wrRequest   = wrEn & (paddr == tiu_pkg::TIU_OFS_REQUEST);
    always_comb begin
        case (paddr)
            tiu_pkg::TIU_OFS_RELOAD1,
            tiu_pkg::TIU_OFS_RELOAD2,
            tiu_pkg::TIU_OFS_COUNT1,
            tiu_pkg::TIU_OFS_COUNT2,
            tiu_pkg::TIU_OFS_MASK,
            tiu_pkg::TIU_OFS_REQUEST: mapped = 1'b1;
            default:                  mapped = 1'b0;
        endcase
    end

    // Reload of timer one; state only changes on real clock edges
    always_ff @(posedge clk) begin
        if (reset) begin
            reload1_r <= tiu_pkg::TIU_RELOAD_RST;
        end else if (wrReload1) begin
            reload1_r <= pwdata[7:0];
        end
    end

    // Reload of timer two, same layout
    always_ff @(posedge clk) begin
        if (reset) begin
            reload2_r <= tiu_pkg::TIU_RELOAD_RST;
        end else if (wrReload2) begin
            reload2_r <= pwdata[7:0];
        end
    end

    // Mask register, one bit per source
    always_ff @(posedge clk) begin
        if (reset) begin
            interruptMaskReg_r <= tiu_pkg::TIU_MASK_RST;
        end else if (wrMask) begin
            interruptMaskReg_r <= pwdata[4:0];
        end
    end

    // Rising edge of the synchronised pin, read only from the second stage on
    assign pinRise = pinSync_r[1] & ~pinSync_r[2];

    // Source events gathered into request positions
    always_comb begin
        events = 5'h00;
        events[tiu_pkg::TIU_SRC_EXT_EDGE]   = pinRise;
        events[tiu_pkg::TIU_SRC_TIMER1]     = ovf1;
        events[tiu_pkg::TIU_SRC_TIMER2]     = ovf2;
        events[tiu_pkg::TIU_SRC_RESERVED]   = reservedEvent;
        events[tiu_pkg::TIU_SRC_PWM_PERIOD] = pwmPeriodDone;
    end

    // Sticky requests, write one to clear; a new event beats a same-cycle clear
    always_comb begin
        request_nxt = request_r;
        if (wrRequest) begin
            request_nxt = request_nxt & ~pwdata[4:0];
        end
        request_nxt = request_nxt | events;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            request_r <= tiu_pkg::TIU_REQUEST_RST;
        end else begin
            request_r <= request_nxt;
        end
    end

    // Any enabled request keeps the interrupt pending
    assign irqPending = |(request_r & interruptMaskReg_r);

    // Interrupt from a flop, one cycle after the request bit shows
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= irqPending;
        end
    end

    // APB answer: ready with the access phase, error on unmapped address
    assign rdSetup  = psel & ~penable & ~pwrite;
    assign readyNxt = psel & ~penable & ~pready;
    assign errNxt   = readyNxt & ~mapped;

    // Read mux, taken in the setup cycle so the data stands with pready
    always_comb begin
        readMux = 32'h00000000;
        case (paddr)
            tiu_pkg::TIU_OFS_RELOAD1: readMux = {24'h000000, reload1_r};
            tiu_pkg::TIU_OFS_RELOAD2: readMux = {24'h000000, reload2_r};
            tiu_pkg::TIU_OFS_COUNT1:  readMux = {24'h000000, count1};
            tiu_pkg::TIU_OFS_COUNT2:  readMux = {24'h000000, count2};
            tiu_pkg::TIU_OFS_MASK:    readMux = {27'h0000000, interruptMaskReg_r};
            tiu_pkg::TIU_OFS_REQUEST: readMux = {27'h0000000, request_r};
            default:                  readMux = 32'h00000000;
        endcase
    end

    // Ready pulse, exactly one access cycle long
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= readyNxt;
        end
    end

    // Error flag rides with pready on an unmapped address
    always_ff @(posedge clk) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= errNxt;
        end
    end

    // Read data is zero outside the access cycle, so stale values never leak
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rdSetup) begin
            prdata <= readMux;
        end else begin
            prdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// [dv/tiu_checker.sv]
// Port assertions for the timer and interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tiu_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Bus timing: zero wait states, one-cycle answer
    property p_rdy; psel && !penable ##1 psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready in access");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("pready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("lone pslverr");
    property p_map; psel && !penable && paddr > 8'h14 ##1 penable |-> pslverr && prdata == 32'h0;
    endproperty
    a_map: assert property (p_map) else $error("unmapped not refused");
    // Registers are at most eight bits wide, so the upper read bits stay zero
    property p_hi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("prdata outside access");
    property p_rst; $fell(reset) |-> !irq && !pready; endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    // Masking every source must drop the interrupt within two edges
    property p_irq; psel && penable && pready && pwrite && paddr == 8'h10
        && pwdata[4:0] == 5'h0 |-> ##[1:2] !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq with all masked");
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_low: cover property ($fell(irq));
endmodule
bind timer_interrupt_unit tiu_checker i_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// [dv/tiu_proc_model.sv]
// Processor core model: APB master, one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module tiu_proc_model (
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    // Bus idle at time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Request held until pready is seen; a hang returns an unknown error flag
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = (pready === 1'b1) ? pslverr : 1'bx;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the timer and interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, irq, err;
    logic        pin = 1'b0;
    logic        fastOsc = 1'b0;
    logic        slowOsc = 1'b0;
    logic        pwm = 1'b0;
    logic        rsv = 1'b0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          failures = 0;
    int          compares = 0;
    int          seed = 40051;
    int          rl [2];
    int          cs [2] = '{0, 0};
    int          evs [3] = '{0, 3, 4};
    int          req = 0;
    int          n;
    always #4 clk = ~clk;
    tiu_proc_model i_cpu (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    timer_interrupt_unit i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .firstPortLowestPin(pin), .fastOscInput(fastOsc),
        .slowOscInput(slowOsc), .pwmPeriodDone(pwm), .reservedEvent(rsv), .irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        i_cpu.xfer(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input int exp);
        i_cpu.xfer(1'b0, a, 32'h0, rd, err);
        chk({err, rd[30:0]}, exp);
    endtask
    // One-cycle event pulse, then time for sync and request update
    task automatic ev(input int s);
        @(posedge clk);
        pin <= (s == 0);
        rsv <= (s == 3);
        pwm <= (s == 4);
        @(posedge clk);
        {pin, rsv, pwm} <= 3'h0;
        repeat (4) @(posedge clk);
        req |= 1 << s;
    endtask
    // Oscillator ticks kept well under half the bus clock
    task automatic tk(input int i, input int k);
        repeat (k) begin
            @(posedge clk);
            fastOsc <= (i == 1);
            slowOsc <= (i == 2);
            repeat (3) @(posedge clk);
            {fastOsc, slowOsc} <= 2'h0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    // Watchdog against a stuck run
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            rl[i] = $random(seed) & 8'h7F;
            wr(8'(4 * i), rl[i]);
            rdc(tiu_pkg::TIU_OFS_RELOAD1 + 8'(4 * i), rl[i]);
            rdc(tiu_pkg::TIU_OFS_COUNT1 + 8'(4 * i), 0);
        end
        rdc(8'h18, 32'h80000000);
        $display("reload and map test done");
        foreach (evs[k]) begin
            ev(evs[k]);
            rdc(tiu_pkg::TIU_OFS_REQUEST, req);
            wr(tiu_pkg::TIU_OFS_MASK, 1 << evs[k]);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h1);
            wr(tiu_pkg::TIU_OFS_MASK, 5'h1F ^ (1 << evs[k]));
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            wr(tiu_pkg::TIU_OFS_REQUEST, req);
            req = 0;
            rdc(tiu_pkg::TIU_OFS_REQUEST, 0);
        end
        wr(tiu_pkg::TIU_OFS_MASK, 0);
        $display("event test done");
        for (int i = 1; i < 3; i++) begin
            n = 256 + ($random(seed) & 7);
            repeat (n) begin
                if (cs[i - 1] == 255) req |= 1 << i;
                cs[i - 1] = (cs[i - 1] == 255) ? rl[i - 1] : cs[i - 1] + 1;
            end
            tk(i, n);
            rdc(tiu_pkg::TIU_OFS_COUNT1, cs[0]);
            rdc(tiu_pkg::TIU_OFS_COUNT2, cs[1]);
            rdc(tiu_pkg::TIU_OFS_REQUEST, req);
            wr(tiu_pkg::TIU_OFS_REQUEST, req);
            req = 0;
        end
        $display("timer test done");
        test_done();
    end
endmodule
`default_nettype wire
